// file: verification/bpcs_checker.sv
// assertion checker for the battery power check and shutdown block
`timescale 1ns/1ps
module bpcs_checker #(
  parameter int N_CELLS = 5
) (
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire bpcs_pkg::bpcs_axi_req_s axi_req,
  input wire bpcs_pkg::bpcs_axi_rsp_s axi_rsp,
  input wire logic                    normal_mode,
  input wire bpcs_pkg::bpcs_meas_s    meas,
  input wire logic [N_CELLS*16-1:0]   cell_mv,
  input wire logic [N_CELLS-1:0]      cell_used,
  input wire logic                    charge_switch_req,
  input wire logic                    discharge_switch_req,
  input wire logic                    charge_switch,
  input wire logic                    discharge_switch,
  input wire logic                    check_req,
  input wire logic                    shutdown_req
);
  import bpcs_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_mode_off; !normal_mode ##1 !normal_mode; endsequence
  sequence s_rd_take; axi_req.arvalid && axi_rsp.arready; endsequence
  sequence s_wr_take;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence
  property p_chg_follow; charge_switch_req |=> charge_switch; endproperty
  property p_dsg_follow; discharge_switch_req |=> discharge_switch; endproperty
  // assist only ever comes from the opposite switch being wanted on
  property p_chg_cause;
    charge_switch && !$past(charge_switch_req) |-> $past(discharge_switch_req);
  endproperty
  property p_dsg_cause;
    discharge_switch && !$past(discharge_switch_req) |-> $past(charge_switch_req);
  endproperty
  property p_check_idle; s_mode_off |=> !check_req; endproperty
  property p_check_pulse; check_req |=> !check_req; endproperty
  property p_sd_sticky; shutdown_req |=> shutdown_req; endproperty
  property p_rd_answer; s_rd_take |=> axi_rsp.rvalid; endproperty
  property p_wr_answer; s_wr_take |-> ##[1:2] axi_rsp.bvalid; endproperty
  a_chg_follow: assert property (p_chg_follow)
    else $error("charge switch ignored its request");
  a_dsg_follow: assert property (p_dsg_follow)
    else $error("discharge switch ignored its request");
  a_chg_cause: assert property (p_chg_cause)
    else $error("charge switch on without cause");
  a_dsg_cause: assert property (p_dsg_cause)
    else $error("discharge switch on without cause");
  a_check_idle: assert property (p_check_idle)
    else $error("check outside normal mode");
  a_check_pulse: assert property (p_check_pulse)
    else $error("check pulse too long");
  a_sd_sticky: assert property (p_sd_sticky)
    else $error("shutdown request dropped");
  a_rd_answer: assert property (p_rd_answer)
    else $error("read answer late");
  a_wr_answer: assert property (p_wr_answer)
    else $error("write answer late");
endmodule : bpcs_checker
bind bpcs_top bpcs_checker #(.N_CELLS(N_CELLS)) i_chk (
  .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .normal_mode(normal_mode), .meas(meas), .cell_mv(cell_mv), .cell_used(cell_used),
  .charge_switch_req(charge_switch_req), .discharge_switch_req(discharge_switch_req),
  .charge_switch(charge_switch), .discharge_switch(discharge_switch),
  .check_req(check_req), .shutdown_req(shutdown_req)
);

// file: verification/bpcs_meas_model.sv
// measurement front-end model feeding periodic results to the block
`timescale 1ns/1ps
module bpcs_meas_model (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [15:0]        stack_mv,
  input  wire logic signed [15:0] temp_c,
  input  wire logic signed [15:0] sense_uv,
  output bpcs_pkg::bpcs_meas_s    meas
);
  import bpcs_pkg::*;
  logic phase_ff;
  ////////////////////////////////////////////////////////////////////////////////
  // a result lands every other cycle; between results the fields carry junk,
  // so a block that captures without valid is caught
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_ff <= 1'b0;
      meas     <= '0;
    end else begin
      phase_ff <= ~phase_ff;
      meas     <= phase_ff ? {1'b1, stack_mv, temp_c, sense_uv}
                           : {1'b0, ~stack_mv, ~temp_c, ~sense_uv};
    end
  end
endmodule : bpcs_meas_model

// file: verification/tb.sv
// self-checking testbench of the battery power check and shutdown block
`timescale 1ns/1ps
module tb;
  import bpcs_pkg::*;
  localparam int QCYC = 8;
  localparam int SCYC = 4;
  localparam int DCYC = 40;
  logic               aclk;
  logic               aresetn;
  bpcs_axi_req_s      req;
  bpcs_axi_rsp_s      rsp;
  bpcs_meas_s         meas;
  logic               normal_mode;
  logic [79:0]        cell_mv;
  logic [4:0]         cell_used;
  logic               chg_req, dsg_req, charge_switch, discharge_switch, check_req, shutdown_req;
  logic [15:0]        stack_mv;
  logic signed [15:0] temp_c, sense_uv;
  int                 n_fail, samples_checked;
  ////////////////////////////////////////////////////////////////////////////////
  bpcs_top #(.N_CELLS(5), .P_QUARTER_CYC(QCYC), .P_SECOND_CYC(SCYC), .P_DELAY_CYC(DCYC))
  i_dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
    .normal_mode(normal_mode), .meas(meas), .cell_mv(cell_mv), .cell_used(cell_used),
    .charge_switch_req(chg_req), .discharge_switch_req(dsg_req),
    .charge_switch(charge_switch), .discharge_switch(discharge_switch),
    .check_req(check_req), .shutdown_req(shutdown_req));
  bpcs_meas_model i_meas (.aclk(aclk), .aresetn(aresetn), .stack_mv(stack_mv),
    .temp_c(temp_c), .sense_uv(sense_uv), .meas(meas));
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic cmp_w(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_w
  task automatic cmp_b(input string nm, input logic e, input logic g);
    cmp_w(nm, 32'(e), 32'(g));
  endtask : cmp_b
  task automatic tmo(input string nm);
    n_fail++;
    $display("[ERR] %s expected answer seen timeout", nm);
    report_and_stop();
  endtask : tmo
  task automatic cycles(input int k);
    repeat (k) @(posedge aclk);
  endtask : cycles
  // both channels offered together; each dropped once its own ready is seen
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int   k;
    logic done;
    done = 1'b0;
    @(posedge aclk);
    req <= '{1'b1, a, 1'b1, d, 4'hf, 1'b1, 1'b0, 8'h00, 1'b0};
    for (k = 0; k < 50 && !done; k++) begin
      @(posedge aclk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) begin
        req.bready <= 1'b0;
        done = 1'b1;
        cmp_w("bresp", 32'(er), 32'(rsp.bresp));
      end
    end
    if (!done) tmo("write");
  endtask : axi_wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int   k;
    logic done;
    done = 1'b0;
    @(posedge aclk);
    req <= '{1'b0, 8'h00, 1'b0, 32'h0, 4'h0, 1'b0, 1'b1, a, 1'b1};
    for (k = 0; k < 50 && !done; k++) begin
      @(posedge aclk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) begin
        req.rready <= 1'b0;
        done = 1'b1;
        cmp_w("rdata", ed, rsp.rdata);
        cmp_w("rresp", 32'(er), 32'(rsp.rresp));
      end
    end
    if (!done) tmo("read");
  endtask : rd_chk
  task automatic wait_chk;
    int k;
    for (k = 0; k < 100 && check_req !== 1'b1; k++) @(posedge aclk);
    if (k == 100) tmo("check");
  endtask : wait_chk
  // first two periods after a setting change are skipped, the first may be partial
  task automatic gap(input int e);
    int k;
    wait_chk();
    cycles(1);
    wait_chk();
    cycles(1);
    for (k = 1; k < 100 && check_req !== 1'b1; k++) @(posedge aclk);
    cmp_w("check gap", e, k);
  endtask : gap
  task automatic wait_sd(input int bound);
    int k;
    for (k = 0; k < bound && shutdown_req !== 1'b1; k++) @(posedge aclk);
    if (k == bound) tmo("shutdown");
  endtask : wait_sd
  task automatic fresh;
    aresetn <= 1'b0;
    cycles(2);
    aresetn <= 1'b1;
    axi_wr(ADDR_CHECK_INTERVAL, 32'h0, RESP_OKAY);
    normal_mode <= 1'b1;
  endtask : fresh
  task automatic set_sense(input logic [15:0] v);
    sense_uv <= v;
    cycles(6);
  endtask : set_sense
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd_chk(ADDR_CHECK_INTERVAL, 32'h5, RESP_OKAY);
    rd_chk(ADDR_BODY_DIODE, 32'h1, RESP_OKAY);
    rd_chk(ADDR_CELL_SHUTDOWN, 32'h0, RESP_OKAY);
    rd_chk(ADDR_STACK_SHUTDOWN, 32'h0, RESP_OKAY);
    rd_chk(ADDR_TEMP_SHUTDOWN, 32'h0, RESP_OKAY);
    rd_chk(ADDR_CONTROL, 32'h1, RESP_OKAY);
    rd_chk(ADDR_STATUS, 32'h0, RESP_OKAY);
    rd_chk(8'h1c, 32'h0, RESP_SLVERR);
    axi_wr(8'h1c, 32'h1, RESP_SLVERR);
    axi_wr(ADDR_CELL_SHUTDOWN, 32'h1234, RESP_OKAY);
    rd_chk(ADDR_CELL_SHUTDOWN, 32'h1234, RESP_OKAY);
    axi_wr(ADDR_CELL_SHUTDOWN, 32'h0, RESP_OKAY);
    $display("test regs done");
  endtask : t_regs
  task automatic t_check;
    normal_mode <= 1'b1;
    gap(5 * SCYC);
    axi_wr(ADDR_CHECK_INTERVAL, 32'h0, RESP_OKAY);
    gap(QCYC);
    axi_wr(ADDR_CHECK_INTERVAL, 32'h3, RESP_OKAY);
    gap(3 * SCYC);
    normal_mode <= 1'b0;
    cycles(30);
    $display("test check done");
  endtask : t_check
  task automatic t_diode;
    axi_wr(ADDR_BODY_DIODE, 32'h2, RESP_OKAY);
    dsg_req <= 1'b1;
    set_sense(16'hfc18);
    cmp_b("chg at thr", 1'b0, charge_switch);
    set_sense(16'hfc17);
    cmp_b("chg above thr", 1'b1, charge_switch);
    dsg_req <= 1'b0;
    chg_req <= 1'b1;
    set_sense(16'h03e9);
    cmp_b("dsg above thr", 1'b1, discharge_switch);
    set_sense(16'hf830);
    cmp_b("dsg wrong way", 1'b0, discharge_switch);
    axi_wr(ADDR_BODY_DIODE, 32'h0c, RESP_OKAY);
    set_sense(16'h1388);
    cmp_b("dsg at max thr", 1'b0, discharge_switch);
    set_sense(16'h1389);
    cmp_b("dsg above max", 1'b1, discharge_switch);
    axi_wr(ADDR_CONTROL, 32'h0, RESP_OKAY);
    cycles(4);
    cmp_b("dsg parallel", 1'b0, discharge_switch);
    chg_req <= 1'b0;
    $display("test diode done");
  endtask : t_diode
  task automatic t_cell;
    fresh();
    cell_used <= 5'b11011;
    cell_mv[47:32] <= 16'h07d0;
    axi_wr(ADDR_CELL_SHUTDOWN, 32'h0bb8, RESP_OKAY);
    cycles(100);
    cmp_b("unused cell", 1'b0, shutdown_req);
    cell_mv[15:0] <= 16'h0b54;
    cycles(20);
    cell_mv[15:0] <= 16'h0dac;
    cycles(24);
    cell_mv[15:0] <= 16'h0b54;
    cycles(38);
    cmp_b("restarted delay", 1'b0, shutdown_req);
    wait_sd(30);
    cmp_b("cell shutdown", 1'b1, shutdown_req);
    rd_chk(ADDR_STATUS, 32'h413, RESP_OKAY);
    $display("test cell done");
  endtask : t_cell
  task automatic t_stack;
    fresh();
    stack_mv <= 16'h2710;
    cycles(60);
    cmp_b("stack off", 1'b0, shutdown_req);
    axi_wr(ADDR_STACK_SHUTDOWN, 32'h2710, RESP_OKAY);
    cycles(30);
    cmp_b("stack early", 1'b0, shutdown_req);
    wait_sd(50);
    $display("test stack done");
  endtask : t_stack
  task automatic t_temp;
    fresh();
    temp_c <= 16'h0096;
    cycles(30);
    cmp_b("temp off", 1'b0, shutdown_req);
    // lowered first: the new threshold must never meet a stale reading at it
    temp_c <= 16'h0095;
    axi_wr(ADDR_TEMP_SHUTDOWN, 32'hc8, RESP_OKAY);
    cycles(30);
    cmp_b("temp below", 1'b0, shutdown_req);
    temp_c <= 16'h0096;
    wait_sd(20);
    $display("test temp done");
  endtask : t_temp
  initial begin
    aresetn = 1'b0;
    req = '0;
    normal_mode = 1'b0;
    cell_mv = {5{16'h0dac}};
    cell_used = 5'h1f;
    chg_req = 1'b0;
    dsg_req = 1'b0;
    stack_mv = 16'h4e20;
    temp_c = 16'h0019;
    sense_uv = 16'h0000;
    n_fail = 0;
    samples_checked = 0;
    cycles(2);
    aresetn <= 1'b1;
    t_regs();
    t_check();
    t_diode();
    t_cell();
    t_stack();
    t_temp();
    report_and_stop();
  end
endmodule : tb

// file: verilog/bpcs_pkg.sv
// constants, register map and carrier types of the battery power check and shutdown block
package bpcs_pkg;

  localparam int CLK_HZ            = 125_000_000;
  localparam int CHECK_FAST_MS     = 250;
  localparam int SECOND_S          = 1;
  localparam int SHUTDOWN_DELAY_S  = 10;
  localparam int BODY_DIODE_STEP_UV = 500;

  localparam logic [7:0] BODY_DIODE_MIN = 8'h01;
  localparam logic [7:0] BODY_DIODE_MAX = 8'h0a;
  localparam logic [7:0] TEMP_MAX_C     = 8'h96;

  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CHECK_INTERVAL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_BODY_DIODE     = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_CELL_SHUTDOWN  = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_STACK_SHUTDOWN = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_TEMP_SHUTDOWN  = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL        = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_STATUS         = 8'h18;

  localparam logic [7:0]  RST_CHECK_INTERVAL = 8'h05;
  localparam logic [7:0]  RST_BODY_DIODE     = 8'h01;
  localparam logic [15:0] RST_CELL_SHUTDOWN  = 16'h0000;
  localparam logic [15:0] RST_STACK_SHUTDOWN = 16'h0000;
  localparam logic [7:0]  RST_TEMP_SHUTDOWN  = 8'h00;
  localparam logic        RST_SERIES_FET     = 1'b1;

  // control register field
  localparam int CTL_SERIES_FET_BIT = 0;

  // status register fields
  localparam int ST_SHUTDOWN_BIT   = 0;
  localparam int ST_CELL_PEND_BIT  = 1;
  localparam int ST_STACK_PEND_BIT = 2;
  localparam int ST_CAUSE_CELL_BIT = 4;
  localparam int ST_CAUSE_STK_BIT  = 5;
  localparam int ST_CAUSE_TMP_BIT  = 6;
  localparam int ST_CHG_ON_BIT     = 8;
  localparam int ST_DSG_ON_BIT     = 9;
  localparam int ST_NORMAL_BIT     = 10;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } bpcs_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } bpcs_axi_rsp_s;

  // one completed measurement; sense_uv positive means charge current
  typedef struct packed {
    logic               valid;
    logic [15:0]        stack_mv;
    logic signed [15:0] temp_c;
    logic signed [15:0] sense_uv;
  } bpcs_meas_s;

  typedef enum logic [1:0] {
    SD_RUN  = 2'b00,
    SD_PEND = 2'b01,
    SD_DOWN = 2'b11
  } bpcs_sd_state_e;

endpackage : bpcs_pkg

// file: verilog/bpcs_top.sv
// battery power check timer, body-diode switch assist and shutdown decision
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// How it works
// - in normal mode check every N seconds; N of zero checks every 250 ms
// - body-diode threshold is setting times 500 uV, setting held within 1 to 10
// - discharge current above threshold with discharge switch on turns charge switch on
// - charge current above threshold with charge switch on turns discharge switch on
// - series_fet_select of zero disables body-diode assist entirely
// - nonzero signed cell threshold reached for 10 s shuts down; zero disables
// - cells not in use never take part in the cell comparison
// - nonzero stack threshold reached for 10 s shuts down; zero disables
// - nonzero internal temperature threshold reached shuts down; zero disables
module bpcs_top #(
  parameter int N_CELLS       = 5,
  parameter int P_QUARTER_CYC = bpcs_pkg::CLK_HZ / 1000 * bpcs_pkg::CHECK_FAST_MS,
  parameter int P_SECOND_CYC  = bpcs_pkg::CLK_HZ * bpcs_pkg::SECOND_S,
  parameter int P_DELAY_CYC   = bpcs_pkg::CLK_HZ * bpcs_pkg::SHUTDOWN_DELAY_S
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire bpcs_pkg::bpcs_axi_req_s axi_req,
  output bpcs_pkg::bpcs_axi_rsp_s      axi_rsp,
  input  wire logic                    normal_mode,
  input  wire bpcs_pkg::bpcs_meas_s    meas,
  input  wire logic [N_CELLS*16-1:0]   cell_mv,
  input  wire logic [N_CELLS-1:0]      cell_used,
  input  wire logic                    charge_switch_req,
  input  wire logic                    discharge_switch_req,
  output logic                         charge_switch,
  output logic                         discharge_switch,
  output logic                         check_req,
  output logic                         shutdown_req
);
  import bpcs_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // register bus
  logic              awready_ff;
  logic              wready_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0]       wdata_ff;
  logic [3:0]        wstrb_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              arready_ff;
  logic              rvalid_ff;
  logic [31:0]       rdata_ff;
  logic [1:0]        rresp_ff;

  logic [7:0]  check_interval_ff;
  logic [7:0]  body_diode_threshold_ff;
  logic [15:0] cell_shutdown_voltage_ff;
  logic [15:0] stack_shutdown_voltage_ff;
  logic [7:0]  shutdown_temperature_ff;
  logic        series_fet_select_ff;

  wire aw_take  = axi_req.awvalid & awready_ff;
  wire w_take   = axi_req.wvalid & wready_ff;
  wire ar_take  = axi_req.arvalid & arready_ff;
  wire b_done   = bvalid_ff & axi_req.bready;
  wire r_done   = rvalid_ff & axi_req.rready;
  wire do_write = ~awready_ff & ~wready_ff & ~bvalid_ff;

  wire wsel_check = do_write & (awaddr_ff == ADDR_CHECK_INTERVAL);
  wire wsel_bd    = do_write & (awaddr_ff == ADDR_BODY_DIODE);
  wire wsel_cell  = do_write & (awaddr_ff == ADDR_CELL_SHUTDOWN);
  wire wsel_stack = do_write & (awaddr_ff == ADDR_STACK_SHUTDOWN);
  wire wsel_temp  = do_write & (awaddr_ff == ADDR_TEMP_SHUTDOWN);
  wire wsel_ctl   = do_write & (awaddr_ff == ADDR_CONTROL);
  wire w_mapped   = wsel_check | wsel_bd | wsel_cell | wsel_stack | wsel_temp | wsel_ctl
                    | (awaddr_ff == ADDR_STATUS);

  // status is read-only; a write there is accepted and ignored
  wire [15:0] wr_half = {wstrb_ff[1] ? wdata_ff[15:8] : cell_shutdown_voltage_ff[15:8],
                         wstrb_ff[0] ? wdata_ff[7:0] : cell_shutdown_voltage_ff[7:0]};
  wire [15:0] wr_stk  = {wstrb_ff[1] ? wdata_ff[15:8] : stack_shutdown_voltage_ff[15:8],
                         wstrb_ff[0] ? wdata_ff[7:0] : stack_shutdown_voltage_ff[7:0]};
  wire        wr_lo   = wstrb_ff[0];

  logic [31:0] status_word;
  logic [31:0] rd_data;
  logic        rd_ok;

  always_comb begin
    rd_ok   = 1'b1;
    rd_data = 32'h0000_0000;
    case (axi_req.araddr)
      ADDR_CHECK_INTERVAL: rd_data[7:0]  = check_interval_ff;
      ADDR_BODY_DIODE:     rd_data[7:0]  = body_diode_threshold_ff;
      ADDR_CELL_SHUTDOWN:  rd_data[15:0] = cell_shutdown_voltage_ff;
      ADDR_STACK_SHUTDOWN: rd_data[15:0] = stack_shutdown_voltage_ff;
      ADDR_TEMP_SHUTDOWN:  rd_data[7:0]  = shutdown_temperature_ff;
      ADDR_CONTROL:        rd_data[CTL_SERIES_FET_BIT] = series_fet_select_ff;
      ADDR_STATUS:         rd_data = status_word;
      default:             rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      awaddr_ff  <= '0;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        awready_ff <= 1'b0;
        awaddr_ff  <= axi_req.awaddr;
      end
      if (w_take) begin
        wready_ff <= 1'b0;
        wdata_ff  <= axi_req.wdata;
        wstrb_ff  <= axi_req.wstrb;
      end
      if (do_write) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= w_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (b_done) begin
        bvalid_ff  <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= RESP_OKAY;
    end else if (ar_take) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rdata_ff   <= rd_data;
      rresp_ff   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (r_done) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      check_interval_ff         <= RST_CHECK_INTERVAL;
      body_diode_threshold_ff   <= RST_BODY_DIODE;
      cell_shutdown_voltage_ff  <= RST_CELL_SHUTDOWN;
      stack_shutdown_voltage_ff <= RST_STACK_SHUTDOWN;
      shutdown_temperature_ff   <= RST_TEMP_SHUTDOWN;
      series_fet_select_ff      <= RST_SERIES_FET;
    end else begin
      if (wsel_check && wr_lo) check_interval_ff <= wdata_ff[7:0];
      if (wsel_bd && wr_lo)    body_diode_threshold_ff <= wdata_ff[7:0];
      if (wsel_cell)           cell_shutdown_voltage_ff <= wr_half;
      if (wsel_stack)          stack_shutdown_voltage_ff <= wr_stk;
      if (wsel_temp && wr_lo)  shutdown_temperature_ff <= wdata_ff[7:0];
      if (wsel_ctl && wr_lo)   series_fet_select_ff <= wdata_ff[CTL_SERIES_FET_BIT];
    end
  end

  assign axi_rsp.awready = awready_ff;
  assign axi_rsp.wready  = wready_ff;
  assign axi_rsp.bvalid  = bvalid_ff;
  assign axi_rsp.bresp   = bresp_ff;
  assign axi_rsp.arready = arready_ff;
  assign axi_rsp.rvalid  = rvalid_ff;
  assign axi_rsp.rdata   = rdata_ff;
  assign axi_rsp.rresp   = rresp_ff;

  //////////////////////////////////////////////////////////////////////////////
  // periodic check timer
  logic [31:0] tick_ff;
  logic [7:0]  sec_ff;
  logic        check_ff;

  wire        fast_mode  = (check_interval_ff == 8'h00);
  wire [31:0] period_end = fast_mode ? 32'(P_QUARTER_CYC - 1) : 32'(P_SECOND_CYC - 1);
  wire        tick_wrap  = (tick_ff == period_end);
  // >= so that shrinking the interval mid-count never skips a check
  wire        sec_last   = ({1'b0, sec_ff} + 9'h001) >= {1'b0, check_interval_ff};
  wire        check_now  = normal_mode & tick_wrap & (fast_mode | sec_last);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_ff  <= 32'h0000_0000;
      sec_ff   <= 8'h00;
      check_ff <= 1'b0;
    end else begin
      check_ff <= check_now;
      if (!normal_mode || tick_wrap || tick_ff > period_end) begin
        tick_ff <= 32'h0000_0000;
      end else begin
        tick_ff <= tick_ff + 32'h0000_0001;
      end
      if (!normal_mode || check_now || fast_mode) begin
        sec_ff <= 8'h00;
      end else if (tick_wrap) begin
        sec_ff <= sec_ff + 8'h01;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // latest completed measurement
  bpcs_meas_s            meas_ff;
  logic [N_CELLS*16-1:0] cell_mv_ff;
  logic [N_CELLS-1:0]    cell_used_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meas_ff      <= '0;
      cell_mv_ff   <= '0;
      cell_used_ff <= '0;
    end else if (meas.valid) begin
      meas_ff      <= meas;
      cell_mv_ff   <= cell_mv;
      cell_used_ff <= cell_used;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // body-diode assist
  wire [7:0] bd_set = (body_diode_threshold_ff < BODY_DIODE_MIN) ? BODY_DIODE_MIN :
                      (body_diode_threshold_ff > BODY_DIODE_MAX) ? BODY_DIODE_MAX :
                      body_diode_threshold_ff;
  wire signed [17:0] bd_uv   = $signed({2'b00, 16'(bd_set * BODY_DIODE_STEP_UV)});
  wire signed [17:0] sense   = 18'(meas_ff.sense_uv);
  wire               chg_cur = sense > bd_uv;
  wire               dsg_cur = sense < -bd_uv;
  // parallel switches carry no body-diode hazard, so assist stays off
  wire assist_chg = series_fet_select_ff & discharge_switch_req & dsg_cur;
  wire assist_dsg = series_fet_select_ff & charge_switch_req & chg_cur;

  logic chg_sw_ff;
  logic dsg_sw_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chg_sw_ff <= 1'b0;
      dsg_sw_ff <= 1'b0;
    end else begin
      chg_sw_ff <= charge_switch_req | assist_chg;
      dsg_sw_ff <= discharge_switch_req | assist_dsg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // shutdown decision
  logic [N_CELLS-1:0] cell_hit;

  genvar gi;
  generate
    for (gi = 0; gi < N_CELLS; gi++) begin : g_cell
      assign cell_hit[gi] = cell_used_ff[gi] &
        ($signed(cell_mv_ff[gi*16 +: 16]) <= $signed(cell_shutdown_voltage_ff));
    end
  endgenerate

  wire [7:0] temp_thr = (shutdown_temperature_ff > TEMP_MAX_C) ? TEMP_MAX_C
                        : shutdown_temperature_ff;
  wire cell_cond  = (cell_shutdown_voltage_ff != 16'h0000) & (|cell_hit);
  wire stack_cond = (stack_shutdown_voltage_ff != 16'h0000)
                    & (meas_ff.stack_mv <= stack_shutdown_voltage_ff);
  wire temp_cond  = (temp_thr != 8'h00)
                    & (meas_ff.temp_c >= $signed({8'h00, temp_thr}));

  logic [1:0]  cond_ff;
  logic [31:0] dly_ff [2];
  logic [1:0]  fire;
  wire  [1:0]  cond_now = {stack_cond, cell_cond};

  generate
    for (gi = 0; gi < 2; gi++) begin : g_delay
      assign fire[gi] = cond_ff[gi] & (dly_ff[gi] == 32'(P_DELAY_CYC - 1));
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cond_ff[gi] <= 1'b0;
          dly_ff[gi]  <= 32'h0000_0000;
        end else begin
          if (check_ff) cond_ff[gi] <= cond_now[gi];
          // a cleared condition drops the count so the next one starts afresh
          if (!cond_ff[gi] || fire[gi]) begin
            dly_ff[gi] <= 32'h0000_0000;
          end else begin
            dly_ff[gi] <= dly_ff[gi] + 32'h0000_0001;
          end
        end
      end
    end
  endgenerate

  bpcs_sd_state_e sd_ff;
  bpcs_sd_state_e nxt_sd;
  logic [2:0]     cause_ff;
  logic           down_ff;
  wire            temp_trip = check_ff & temp_cond;

  always_comb begin
    nxt_sd = sd_ff;
    case (sd_ff)
      SD_RUN:  if (temp_trip) nxt_sd = SD_DOWN;
               else if (|cond_ff) nxt_sd = SD_PEND;
      SD_PEND: if (temp_trip || |fire) nxt_sd = SD_DOWN;
               else if (~|cond_ff) nxt_sd = SD_RUN;
      SD_DOWN: nxt_sd = SD_DOWN;
      default: nxt_sd = SD_RUN;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sd_ff    <= SD_RUN;
      cause_ff <= 3'h0;
      down_ff  <= 1'b0;
    end else begin
      sd_ff   <= nxt_sd;
      // own flop so the pin carries no decode glitch
      down_ff <= (nxt_sd == SD_DOWN);
      if (sd_ff != SD_DOWN) cause_ff <= cause_ff | {temp_trip, fire};
    end
  end

  // shutdown holds until reset: the supplies are expected to drop anyway
  assign shutdown_req     = down_ff;
  assign check_req        = check_ff;
  assign charge_switch    = chg_sw_ff;
  assign discharge_switch = dsg_sw_ff;

  always_comb begin
    status_word                    = 32'h0000_0000;
    status_word[ST_SHUTDOWN_BIT]   = (sd_ff == SD_DOWN);
    status_word[ST_CELL_PEND_BIT]  = cond_ff[0];
    status_word[ST_STACK_PEND_BIT] = cond_ff[1];
    status_word[ST_CAUSE_CELL_BIT] = cause_ff[0];
    status_word[ST_CAUSE_STK_BIT]  = cause_ff[1];
    status_word[ST_CAUSE_TMP_BIT]  = cause_ff[2];
    status_word[ST_CHG_ON_BIT]     = chg_sw_ff;
    status_word[ST_DSG_ON_BIT]     = dsg_sw_ff;
    status_word[ST_NORMAL_BIT]     = normal_mode;
  end

endmodule : bpcs_top
